// File: std_timer.sv
// Standard 16-bit timer with compare A and compare P, APB register slave
// Behaviour
// R1: Counter bits 15..8 readable in read-only high byte, reset zero.
// R2: Compare A held in two read/write bytes, reset zero.
// R3: Compare P matches counter top byte; zero means 65536-clock period.
// R4: Clear-select low clears on compare P; compare P zero overflows.
// R5: Mode 00 is compare-match output mode.
// R6: Clear-select low sets both match flags on their matches.
// R7: Clear-select high clears on compare A, sets only A flag.
// R8: Software must not program compare A zero in compare mode.
// R9: Compare A zero: counter overflows, no A flag.
// R10: Pin changes only on compare A match in compare mode.
// R11: Compare A match drives pin low, high or toggles per field.
// R12: Pin field: 00 none, 01 low, 10 high, 11 toggle.
// R13: Timer-on rising edge loads pin with output-control level.
// R14: Timer-on rise zeroes counter; fall stops and holds it.
// R15: Mode 11 acts like compare mode without using the pin.
// R16: Mode 10 is PWM; swap bit picks period register.
// R17: PWM mode sets both flags on their matches.
// R18: PWM level, enable/force, and invert set by control bits.
// R19: Swap zero: period compare P times 256, duty compare A.
// R20: Duty at or above period gives 100 percent duty.
// R21: Swap one: period compare A, duty compare P times 256.
// R22: Counter increments on each timer clock while on, unpaused.
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "std_timer_defines.svh"
module std_timer
    import std_timer_pkg::*;
(
    input  wire logic        pclk,        // APB clock, 125 MHz
    input  wire logic        presetn,     // Async reset, active low
    input  wire logic        psel,        // APB select
    input  wire logic        penable,     // APB access phase
    input  wire logic        pwrite,      // APB write
    input  wire logic [11:0] paddr,       // APB byte address
    input  wire logic [31:0] pwdata,      // APB write data
    input  wire logic [3:0]  pstrb,       // APB byte strobes
    output logic             pready,      // APB ready
    output logic [31:0]      prdata,      // APB read data
    output logic             pslverr,     // APB error
    output logic             timer_out,   // Timer output pin level
    output logic             timer_out_oe // Pin driven by timer
);

    // ****************************************
    // Registers
    // ****************************************
    logic             pause_ff;
    logic [2:0]       clk_sel_ff;
    logic             timer_on_ff;
    timer_control_1_t ctrl1_ff;
    logic [15:0]      compare_a_ff;
    logic [7:0]       compare_p_ff;
    logic [15:0]      count_ff;
    logic             match_a_flag_ff;
    logic             match_p_flag_ff;
    logic             pin_ff;
    logic             oe_ff;
    logic             pready_ff;
    logic [31:0]      prdata_ff;
    logic             pslverr_ff;
    logic             tick;

    logic [15:0]      nxt_count;
    logic [16:0]      period_len;
    logic [16:0]      duty_len;
    logic [16:0]      cnt_ext;
    logic             pwm_active;
    logic             pin_level;
    match_t           hit;
    logic             do_clear;

    logic             wr_en;
    logic             rd_en;
    logic             addr_ok;
    logic             on_rise;

    assign wr_en = psel && penable && pwrite && !pready_ff;
    assign rd_en = psel && penable && !pwrite && !pready_ff;
    assign pready = pready_ff;
    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff;
    assign timer_out = pin_ff;
    assign timer_out_oe = oe_ff;

    // Decode of the mapped words
    always_comb begin
        case (paddr)
            `TMR_OFF_CONTROL_0, `TMR_OFF_CONTROL_1, `TMR_OFF_CNT_LOW, `TMR_OFF_CNT_HIGH,
            `TMR_OFF_CMPA_LOW, `TMR_OFF_CMPA_HIGH, `TMR_OFF_CMPP, `TMR_OFF_FLAGS: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // Rising edge of timer-on caused by a write this cycle
    assign on_rise = wr_en && pstrb[0] && (paddr == `TMR_OFF_CONTROL_0)
                     && pwdata[`TMR_C0_ON_BIT] && !timer_on_ff;

    // ****************************************
    // Tick source
    // ****************************************
    tick_prescaler u_prescaler (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_sel (clk_sel_ff),
        .run     (timer_on_ff && !pause_ff),
        .tick_ff (tick)
    );

    // ****************************************
    // Comparators
    // ****************************************
    // Compare P against top byte; zero is taken as the overflow point
    always_comb begin
        hit.match_p = (compare_p_ff == 8'h00) ? (count_ff == 16'hFFFF)
                                              : (count_ff == {compare_p_ff - 8'd1, 8'hFF}); // R3 R4
        hit.match_a = (compare_a_ff != 16'h0000) && (count_ff == compare_a_ff - 16'd1); // R9
    end

    // PWM lengths in timer clocks; zero compare P stands for 65536
    always_comb begin
        logic [16:0] p_len;
        p_len = (compare_p_ff == 8'h00) ? 17'h1_0000 : {1'b0, compare_p_ff, 8'h00};
        if (ctrl1_ff.duty_period_swap) begin
            period_len = {1'b0, compare_a_ff};               // R21
            duty_len   = p_len;                              // R21
        end else begin
            period_len = p_len;                              // R19
            duty_len   = {1'b0, compare_a_ff};               // R19
        end
    end

    // Counter clear point per mode and clear-select
    always_comb begin
        nxt_count = count_ff + 16'd1;                        // R22
        if (ctrl1_ff.mode_select == MODE_PWM) begin
            do_clear = ctrl1_ff.duty_period_swap ? hit.match_a : hit.match_p; // R16
        end else if (ctrl1_ff.clear_select) begin
            do_clear = hit.match_a || (compare_a_ff == 16'h0000 && count_ff == 16'hFFFF); // R7 R9
        end else begin
            do_clear = hit.match_p;                          // R4 R5
        end
        if (do_clear) begin
            nxt_count = 16'h0000;
        end
    end

    // PWM waveform: active while count below duty, full when duty covers period
    assign cnt_ext = {1'b0, count_ff};
    assign pwm_active = (duty_len >= period_len) ? 1'b1 : (cnt_ext < duty_len); // R20

    // Pin level in PWM mode
    always_comb begin
        case (ctrl1_ff.pin_function_select)
            PIN_NONE: pin_level = !ctrl1_ff.output_control;  // R18
            PIN_LOW:  pin_level = ctrl1_ff.output_control;   // R18
            PIN_HIGH: pin_level = pwm_active ? ctrl1_ff.output_control : !ctrl1_ff.output_control; // R18
            default:  pin_level = pin_ff;
        endcase
    end

    // ****************************************
    // Counter
    // ****************************************
    // Restart from zero on timer-on rise, hold when off or paused
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff <= 16'h0000;
        end else if (on_rise) begin
            count_ff <= 16'h0000;                            // R14
        end else if (tick) begin
            count_ff <= nxt_count;                           // R22
        end
    end

    // ****************************************
    // Match flags
    // ****************************************
    // Set beats a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_a_flag_ff <= 1'b0;
            match_p_flag_ff <= 1'b0;
        end else begin
            if (tick && hit.match_a) begin
                match_a_flag_ff <= 1'b1;                     // R6 R7 R17
            end else if (wr_en && pstrb[0] && paddr == `TMR_OFF_FLAGS && pwdata[`TMR_FLAG_A_BIT]) begin
                match_a_flag_ff <= 1'b0;
            end
            if (tick && hit.match_p
                && (ctrl1_ff.mode_select == MODE_PWM || !ctrl1_ff.clear_select)) begin
                match_p_flag_ff <= 1'b1;                     // R6 R7 R17
            end else if (wr_en && pstrb[0] && paddr == `TMR_OFF_FLAGS && pwdata[`TMR_FLAG_P_BIT]) begin
                match_p_flag_ff <= 1'b0;
            end
        end
    end

    // ****************************************
    // Output pin
    // ****************************************
    // Pin logic; timer/counter mode releases the pin for other use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_ff <= 1'b0;
            oe_ff  <= 1'b0;
        end else begin
            oe_ff <= (ctrl1_ff.mode_select == MODE_COMPARE) || (ctrl1_ff.mode_select == MODE_PWM); // R15
            if (on_rise) begin
                pin_ff <= ctrl1_ff.output_control ^ ctrl1_ff.output_invert; // R13
            end else if (ctrl1_ff.mode_select == MODE_PWM) begin
                if (ctrl1_ff.pin_function_select != PIN_TOGGLE) begin
                    pin_ff <= pin_level ^ ctrl1_ff.output_invert; // R18
                end
            end else if (ctrl1_ff.mode_select == MODE_COMPARE && tick && hit.match_a) begin
                case (ctrl1_ff.pin_function_select)          // R10 R11 R12
                    PIN_LOW:    pin_ff <= ctrl1_ff.output_invert;
                    PIN_HIGH:   pin_ff <= !ctrl1_ff.output_invert;
                    PIN_TOGGLE: pin_ff <= !pin_ff;
                    default:    pin_ff <= pin_ff;
                endcase
            end
        end
    end

    // ****************************************
    // Control and compare registers
    // ****************************************
    // Byte lane 0 carries every register; other lanes ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pause_ff     <= 1'b0;
            clk_sel_ff   <= 3'b000;
            timer_on_ff  <= 1'b0;
            ctrl1_ff     <= `TMR_RST_BYTE;
            compare_a_ff <= 16'h0000;                        // R2
            compare_p_ff <= `TMR_RST_BYTE;
        end else if (wr_en && pstrb[0]) begin
            case (paddr)
                `TMR_OFF_CONTROL_0: begin
                    pause_ff    <= pwdata[`TMR_C0_PAUSE_BIT];
                    clk_sel_ff  <= pwdata[`TMR_C0_CKSEL_LSB +: 3];
                    timer_on_ff <= pwdata[`TMR_C0_ON_BIT];   // R14
                end
                `TMR_OFF_CONTROL_1: ctrl1_ff            <= pwdata[7:0];
                `TMR_OFF_CMPA_LOW:  compare_a_ff[7:0]   <= pwdata[7:0];  // R2
                `TMR_OFF_CMPA_HIGH: compare_a_ff[15:8]  <= pwdata[7:0];  // R2
                `TMR_OFF_CMPP:      compare_p_ff        <= pwdata[7:0];  // R3
                default: ;                                   // Counter bytes read only
            endcase
        end
    end

    // ****************************************
    // APB answer
    // ****************************************
    // One wait state: ready in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= psel && penable && !pready_ff;
            pslverr_ff <= psel && penable && !pready_ff && !addr_ok;
            prdata_ff  <= 32'h0000_0000;
            if (rd_en) begin
                case (paddr)
                    `TMR_OFF_CONTROL_0: prdata_ff <= {24'h00_0000, pause_ff, clk_sel_ff, timer_on_ff, 3'b000};
                    `TMR_OFF_CONTROL_1: prdata_ff <= {24'h00_0000, ctrl1_ff};
                    `TMR_OFF_CNT_LOW:   prdata_ff <= {24'h00_0000, count_ff[7:0]};
                    `TMR_OFF_CNT_HIGH:  prdata_ff <= {24'h00_0000, count_ff[15:8]}; // R1
                    `TMR_OFF_CMPA_LOW:  prdata_ff <= {24'h00_0000, compare_a_ff[7:0]};
                    `TMR_OFF_CMPA_HIGH: prdata_ff <= {24'h00_0000, compare_a_ff[15:8]};
                    `TMR_OFF_CMPP:      prdata_ff <= {24'h00_0000, compare_p_ff};
                    `TMR_OFF_FLAGS:     prdata_ff <= {30'h0000_0000, match_p_flag_ff, match_a_flag_ff};
                    default:            prdata_ff <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule // std_timer

// File: std_timer_defines.svh
// Offsets, field positions, reset values and timing figures of the standard timer
`ifndef STD_TIMER_DEFINES_SVH
`define STD_TIMER_DEFINES_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define TMR_OFF_CONTROL_0      12'h000
`define TMR_OFF_CONTROL_1      12'h004
`define TMR_OFF_CNT_LOW        12'h008
`define TMR_OFF_CNT_HIGH       12'h00C
`define TMR_OFF_CMPA_LOW       12'h010
`define TMR_OFF_CMPA_HIGH      12'h014
`define TMR_OFF_CMPP           12'h018
`define TMR_OFF_FLAGS          12'h01C

// ****************************************
// Field positions
// ****************************************
`define TMR_C0_PAUSE_BIT       7
`define TMR_C0_CKSEL_LSB       4
`define TMR_C0_ON_BIT          3
`define TMR_FLAG_A_BIT         0
`define TMR_FLAG_P_BIT         1

// ****************************************
// Reset values and prescale figures
// ****************************************
`define TMR_RST_BYTE           8'h00
`define TMR_DIV_SYS4           8'd3
`define TMR_DIV_H16            8'd15
`define TMR_DIV_H64            8'd63
`define TMR_DIV_SUB            8'd255

`endif

// File: std_timer_pkg.sv
// Types shared by the standard timer files
package std_timer_pkg;

    typedef enum logic [1:0] {
        MODE_COMPARE = 2'b00,
        MODE_UNDEF   = 2'b01,
        MODE_PWM     = 2'b10,
        MODE_TIMER   = 2'b11
    } mode_select_t;

    typedef enum logic [1:0] {
        PIN_NONE   = 2'b00,
        PIN_LOW    = 2'b01,
        PIN_HIGH   = 2'b10,
        PIN_TOGGLE = 2'b11
    } pin_function_t;

    // Second control byte as software sees it
    typedef struct packed {
        mode_select_t  mode_select;
        pin_function_t pin_function_select;
        logic          output_control;
        logic          output_invert;
        logic          duty_period_swap;
        logic          clear_select;
    } timer_control_1_t;

    // Comparator results of one timer tick
    typedef struct packed {
        logic match_a;
        logic match_p;
    } match_t;

endpackage

// File: tick_prescaler.sv
// Timer clock tick generator selecting a divided rate of pclk
`timescale 1ns/1ps
`include "std_timer_defines.svh"
module tick_prescaler
    import std_timer_pkg::*;
(
    input  wire logic       pclk,     // System clock
    input  wire logic       presetn,  // Async reset, low
    input  wire logic [2:0] clk_sel,  // Rate select
    input  wire logic       run,      // Counting enabled
    output logic            tick_ff   // One-cycle timer clock
);

    logic [7:0] div_ff;
    logic [7:0] limit;

    // Rate table; sub clock is approximated by the slowest divide
    always_comb begin
        case (clk_sel)
            3'b000:  limit = `TMR_DIV_SYS4;
            3'b001:  limit = 8'd0;
            3'b010:  limit = `TMR_DIV_H16;
            3'b011:  limit = `TMR_DIV_H64;
            default: limit = `TMR_DIV_SUB;
        endcase
    end

    // Free divider, cleared to zero while stopped so restart timing is repeatable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff  <= 8'h00;
            tick_ff <= 1'b0;
        end else if (!run) begin
            div_ff  <= 8'h00;
            tick_ff <= 1'b0;
        end else if (div_ff >= limit) begin
            div_ff  <= 8'h00;
            tick_ff <= 1'b1;
        end else begin
            div_ff  <= div_ff + 8'd1;
            tick_ff <= 1'b0;
        end
    end

endmodule // tick_prescaler

// File: std_timer_asserts.sv
// Concurrent checks on the standard timer APB ports and pin enable
`timescale 1ns/1ps
`include "std_timer_defines.svh"
module std_timer_asserts (
    input wire logic        pclk,        // APB clock
    input wire logic        presetn,     // Async reset, low
    input wire logic        psel,        // APB select
    input wire logic        penable,     // APB access phase
    input wire logic        pwrite,      // APB write
    input wire logic [11:0] paddr,       // APB address
    input wire logic [31:0] pwdata,      // APB write data
    input wire logic [3:0]  pstrb,       // APB strobes
    input wire logic        pready,      // APB ready
    input wire logic [31:0] prdata,      // APB read data
    input wire logic        pslverr,     // APB error
    input wire logic        timer_out,   // Pin level
    input wire logic        timer_out_oe // Pin enable
);
    logic [7:0] shadow_a_ff;
    logic [1:0] shadow_mode_ff;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Expected compare A low byte, follows completed writes only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shadow_a_ff <= 8'h00;
        end else if (pready && pwrite && pstrb[0] && paddr == `TMR_OFF_CMPA_LOW) begin
            shadow_a_ff <= pwdata[7:0];
        end
    end

    // Expected mode field, follows completed control writes; drives the pin enable check
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shadow_mode_ff <= 2'b00;
        end else if (pready && pwrite && pstrb[0] && paddr == `TMR_OFF_CONTROL_1) begin
            shadow_mode_ff <= pwdata[7:6];
        end
    end

    a_pin_enable_mode: assert property ($past(presetn) |-> timer_out_oe == !shadow_mode_ff[0])
        else $error("pin enable does not follow mode");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready stood longer than one cycle");
    a_ready_after_access: assert property (psel && penable && !pready |=> pready)
        else $error("no ready one cycle after access");
    a_ready_has_cause: assert property (pready |-> $past(psel) && $past(penable))
        else $error("ready without an access");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error outside ready");
    a_unmapped_err: assert property (psel && penable && !pready && paddr > 12'h01C |=> pslverr)
        else $error("unmapped address not refused");
    a_mapped_no_err: assert property (psel && penable && !pready && paddr <= 12'h01C && paddr[1:0] == 2'b00
        |=> !pslverr)
        else $error("mapped address refused");
    a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    a_cmpa_readback: assert property (pready && !pwrite && paddr == `TMR_OFF_CMPA_LOW
        |-> prdata[7:0] == shadow_a_ff)
        else $error("compare A low byte readback wrong");
endmodule // std_timer_asserts

bind std_timer std_timer_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .timer_out(timer_out), .timer_out_oe(timer_out_oe));

// File: tb_top.sv
// Self-checking testbench of the standard timer
`timescale 1ns/1ps
`include "std_timer_defines.svh"
module tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'hF;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        timer_out;
    logic        timer_out_oe;
    int          n_fail = 0;
    int          compares = 0;
    logic [31:0] rd;
    logic [31:0] rd2;
    logic        er;

    std_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .timer_out(timer_out), .timer_out_oe(timer_out_oe));

    // 125 MHz clock
    always #4 pclk = ~pclk;

    // ****************************************
    // Tasks
    // ****************************************
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One APB transfer; held until ready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= 32'(d);
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            chk(32'h0000_0000, 32'h0000_0001, "no ready");
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(1'b1, a, d, rd2, er);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
        xfer(1'b0, a, 8'h00, rd2, er);
        chk(rd2, exp, what);
        chk(32'(er), 32'h0000_0000, "error flag");
    endtask

    // Restart with new settings, then count pin-high cycles over a window
    task automatic pwm_run(input logic [7:0] c1, input logic [15:0] a, input logic [7:0] p,
                           input int win, input int exp);
        int hi;
        hi = 0;
        wr(`TMR_OFF_CONTROL_0, 8'h00);
        wr(`TMR_OFF_CONTROL_1, c1);
        wr(`TMR_OFF_CMPA_LOW, a[7:0]);
        wr(`TMR_OFF_CMPA_HIGH, a[15:8]);
        wr(`TMR_OFF_CMPP, p);
        wr(`TMR_OFF_CONTROL_0, 8'h18);
        repeat (20) @(posedge pclk);
        repeat (win) begin
            @(posedge pclk);
            if (timer_out === 1'b1) begin
                hi++;
            end
        end
        chk(32'(hi), 32'(exp), "pwm active cycles");
        $display("test pwm %h done", c1);
    endtask

    // Hang guard, well above the expected run length
    initial begin
        repeat (60000) @(posedge pclk);
        chk(32'h0000_0000, 32'h0000_0001, "watchdog");
        give_verdict();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and read-only counter byte
        rdchk(`TMR_OFF_CMPA_LOW, 32'h0000_0000, "cmpa low reset");
        rdchk(`TMR_OFF_CMPA_HIGH, 32'h0000_0000, "cmpa high reset");
        rdchk(`TMR_OFF_CMPP, 32'h0000_0000, "cmpp reset");
        wr(`TMR_OFF_CNT_HIGH, 8'hFF);
        rdchk(`TMR_OFF_CNT_HIGH, 32'h0000_0000, "counter high byte");
        wr(`TMR_OFF_CMPA_HIGH, 8'hA5);
        rdchk(`TMR_OFF_CMPA_HIGH, 32'h0000_00A5, "cmpa high readback");
        xfer(1'b0, 12'h040, 8'h00, rd, er);
        chk(32'(er), 32'h0000_0001, "unmapped error");
        $display("test registers done");
        // Compare mode, clear on A: pin driven high, only A flag
        wr(`TMR_OFF_CONTROL_1, 8'h21);
        wr(`TMR_OFF_CMPA_LOW, 8'h0A);
        rdchk(`TMR_OFF_CMPA_LOW, 32'h0000_000A, "cmpa low readback");
        wr(`TMR_OFF_CMPA_HIGH, 8'h00);
        wr(`TMR_OFF_CMPP, 8'h01);
        wr(`TMR_OFF_CONTROL_0, 8'h18);
        chk(32'({timer_out, timer_out_oe}), 32'h0000_0001, "initial pin");
        repeat (300) @(posedge pclk);
        chk(32'(timer_out), 32'h0000_0001, "pin after match A");
        rdchk(`TMR_OFF_FLAGS, 32'h0000_0001, "only A flag");
        wr(`TMR_OFF_CONTROL_0, 8'h00);
        xfer(1'b0, `TMR_OFF_CNT_LOW, 8'h00, rd, er);
        repeat (10) @(posedge pclk);
        rdchk(`TMR_OFF_CNT_LOW, rd, "stopped counter holds");
        $display("test compare clear A done");
        // Compare mode, clear on P, toggle: two A matches in the window, a P toggle would show
        wr(`TMR_OFF_FLAGS, 8'h03);
        wr(`TMR_OFF_CONTROL_1, 8'h38);
        wr(`TMR_OFF_CONTROL_0, 8'h18);
        repeat (300) @(posedge pclk);
        rdchk(`TMR_OFF_FLAGS, 32'h0000_0003, "both flags");
        rdchk(`TMR_OFF_CNT_HIGH, 32'h0000_0000, "cleared by P match");
        chk(32'(timer_out), 32'h0000_0001, "pin unchanged");
        $display("test compare clear P done");
        // Timer mode: pin unused, A flag as in compare mode
        wr(`TMR_OFF_CONTROL_0, 8'h00);
        wr(`TMR_OFF_FLAGS, 8'h03);
        wr(`TMR_OFF_CONTROL_1, 8'hC1);
        wr(`TMR_OFF_CONTROL_0, 8'h18);
        repeat (40) @(posedge pclk);
        rdchk(`TMR_OFF_FLAGS, 32'h0000_0001, "timer mode flag");
        chk(32'(timer_out_oe), 32'h0000_0000, "pin unused");
        $display("test timer mode done");
        // PWM cases: duty, full duty, invert, forced level, swapped roles
        wr(`TMR_OFF_FLAGS, 8'h03);
        pwm_run(8'hA8, 16'h0040, 8'h01, 512, 128);
        rdchk(`TMR_OFF_FLAGS, 32'h0000_0003, "pwm flags");
        pwm_run(8'hA8, 16'h012C, 8'h01, 512, 512);
        pwm_run(8'hAC, 16'h0040, 8'h01, 512, 384);
        pwm_run(8'h88, 16'h0040, 8'h01, 512, 0);
        pwm_run(8'hAB, 16'h0200, 8'h01, 1024, 512);
        give_verdict();
    end
endmodule // tb_top
